// ===== rtl/lpc_pin_edges.sv
`timescale 1ns/1ns
module lpc_pin_edges
  import lpc_sd_pkg::*;
(
  // Clock and reset
  input  wire logic    clk_sys,
  input  wire logic    reset,
  // Synchronised pins
  pin_sync_if.consumer pins,
  // Edge pulses
  output logic         lclk_rise,
  output logic         lclk_fall,
  output logic         lpcpd_rise,
  output logic         lpcpd_fall
);

  logic lclk_q;
  logic lpcpd_q;

  // Previous levels; power-down resets high so no false rise appears.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      lclk_q  <= 1'b0;
      lpcpd_q <= 1'b1;
    end
    else
    begin
      lclk_q  <= pins.lclk;
      lpcpd_q <= pins.lpcpd_n;
    end
  end

  // Edges compare the synchronised level with its previous value.
  assign lclk_rise  = pins.lclk & ~lclk_q;
  assign lclk_fall  = ~pins.lclk & lclk_q;
  assign lpcpd_rise = pins.lpcpd_n & ~lpcpd_q;
  assign lpcpd_fall = ~pins.lpcpd_n & lpcpd_q;

endmodule : lpc_pin_edges

// ===== rtl/lpc_pin_sync.sv
`timescale 1ns/1ns
module lpc_pin_sync
  import lpc_sd_pkg::*;
(
  // Clock
  input  wire logic       clk_sys,
  // Raw pins from the host side
  input  wire logic [4:0] raw,
  // Synchronised levels
  pin_sync_if.producer    pins
);

  logic [4:0] meta_q;
  logic [4:0] sync_q;

  // Two flops per pin; only the second stage is ever read.
  always_ff @(posedge clk_sys)
  begin
    meta_q <= raw;
    sync_q <= meta_q;
  end

  assign pins.lreset_n = sync_q[0];
  assign pins.lpcpd_n  = sync_q[1];
  assign pins.lclk     = sync_q[2];
  assign pins.serirq   = sync_q[3];
  assign pins.lframe_n = sync_q[4];

endmodule : lpc_pin_sync

// ===== rtl/lpc_sd_pkg.sv
package lpc_sd_pkg;

  // Register byte offsets.
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_HIRQ   = 8'h0c;
  localparam logic [7:0] ADDR_HSHAKE = 8'h10;

  // Control register fields.
  localparam int CTRL_SWSD    = 0;
  localparam int CTRL_SDEN    = 1;
  localparam int CTRL_SWRST   = 2;
  localparam int CTRL_ERROR_IRQ_ENABLE   = 3;
  localparam int CTRL_CLRMODE = 4;

  // Configuration register fields.
  localparam int CFG_CHEN     = 0;
  localparam int CFG_WAKE_SEL = 4;
  localparam int CFG_SMI_SEL  = 5;
  localparam int CFG_SCI_SEL  = 6;
  localparam int CFG_A20_SEL  = 7;
  localparam int CFG_CLOCK_REQUEST_FLAG   = 8;

  // Status write-one-to-clear fields and handshake fields.
  localparam int STAT_SDFLAG = 0;
  localparam int STAT_ABORT  = 5;
  localparam int HS_OBF      = 0;
  localparam int HS_IBF      = 4;

  // Values after reset.
  localparam logic [8:0]  CFG_RST   = 9'h000;
  localparam logic [17:0] HIRQ_RST  = 18'h00000;
  localparam logic        A20_RST   = 1'b1;
  localparam logic        QUIET_RST = 1'b0;

  // Frames each source may drive; bit n stands for frame n.
  localparam logic [17:0] MASK_CH1  = 18'h02004;
  localparam logic [17:0] MASK_CH23 = 18'h01c88;
  localparam logic [17:0] MASK_CH4  = 18'h1fffc;
  localparam logic [17:0] MASK_FIFO = 18'h1fffc;

  // Serialized interrupt cycle shape.
  localparam logic [4:0] LAST_FRAME  = 5'd17;
  localparam logic [2:0] STOP_QUIET  = 3'd2;
  localparam logic [1:0] PH_TURN     = 2'd2;

  // Link clock counted as stopped after this long without an edge.
  localparam int CLK_NS        = 4;
  localparam int LCLK_STOP_NS  = 200;
  localparam logic [7:0] LCLK_STOP_CYC = 8'((LCLK_STOP_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SLAVE = 3'b001,
    ST_START = 3'b010,
    ST_FRAME = 3'b011,
    ST_STOP  = 3'b100
  } serirq_state_type;

endpackage : lpc_sd_pkg

// ===== rtl/lpc_shutdown_reset_serirq.sv
`timescale 1ns/1ns
module lpc_shutdown_reset_serirq
  import lpc_sd_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Host-side pins, asynchronous
  input  wire logic        lpc_reset_n,
  input  wire logic        power_down_n,
  input  wire logic        lclk,
  input  wire logic        serirq_i,
  input  wire logic        lframe_n_i,
  // Serialized interrupt and clock-run pins
  output logic             serirq_o,
  output logic             serirq_oe_n,
  output logic             clkrun_o,
  output logic             clkrun_oe_n,
  // Address-data pins and cycle engine
  input  wire logic [3:0]  engine_lad_o,
  input  wire logic        engine_lad_drive,
  output logic      [3:0]  lad_o,
  output logic             lad_oe_n,
  output logic             lframe_n_seen,
  output logic             engine_reset,
  // Transfer engine events
  input  wire logic        xfer_start,
  input  wire logic        xfer_done,
  input  wire logic        xfer_abort,
  // Channel handshake events
  input  wire logic [3:0]  hs_ibf_set,
  input  wire logic [3:0]  hs_cmd,
  input  wire logic [3:0]  hs_obf_clear,
  input  wire logic        a20_write,
  input  wire logic        a20_value,
  // Serial unit interrupt requests, one per frame
  input  wire logic [17:0] fifo_irq_req,
  // Sideband pins: wake, smi, sci, gate a20
  input  wire logic [2:0]  side_func_o,
  input  wire logic [3:0]  side_port_o,
  input  wire logic [3:0]  side_port_oe_n,
  output logic      [3:0]  side_o,
  output logic      [3:0]  side_oe_n,
  // Processor interrupt
  output logic             error_interrupt
);

  localparam logic [3:0][17:0] CH_MASK = {MASK_CH4, MASK_CH23, MASK_CH23, MASK_CH1};

  pin_sync_if pins ();

  logic lclk_rise;
  logic lclk_fall;
  logic lpcpd_rise;
  logic lpcpd_fall;

  lpc_pin_sync u_sync (
    .clk_sys (clk_sys),
    .raw     ({lframe_n_i, serirq_i, lclk, power_down_n, lpc_reset_n}),
    .pins    (pins)
  );

  lpc_pin_edges u_edges (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .pins       (pins),
    .lclk_rise  (lclk_rise),
    .lclk_fall  (lclk_fall),
    .lpcpd_rise (lpcpd_rise),
    .lpcpd_fall (lpcpd_fall)
  );

  // Registers.
  logic             swsd_q, swsd_d;
  logic             sden_q, sden_d;
  logic             swrst_q, swrst_d;
  logic             error_irq_enable_q;
  logic [2:0]       clrmode_q;
  logic [8:0]       cfg_q;
  logic [17:0]      hirq_q, hirq_d;
  logic             quiet_q;
  logic [3:0]       obf_q;
  logic [3:0]       ibf_q;
  logic [3:0]       cd_q;
  logic             a20_q;
  logic             hwsd_q, hwsd_d;
  logic             insd_q;
  logic             sdflag_q;
  logic             busy_q;
  logic             abort_q;
  logic             clock_request_flag_q;
  logic [7:0]       idle_cnt_q;
  logic             smp_q;
  serirq_state_type st_q, st_d;
  logic [4:0]       frame_q, frame_d;
  logic [1:0]       phase_q, phase_d;
  logic [2:0]       lows_q, lows_d;
  logic             drove_q, drove_d;
  logic             ser_o_d, ser_oe_n_d;
  logic             quiet_d;

  // Decode.
  wire wr_ctrl   = reg_wr & (reg_addr == ADDR_CTRL);
  wire wr_cfg    = reg_wr & (reg_addr == ADDR_CONFIG);
  wire wr_stat   = reg_wr & (reg_addr == ADDR_STATUS);
  wire wr_hirq   = reg_wr & (reg_addr == ADDR_HIRQ);
  wire wr_hs     = reg_wr & (reg_addr == ADDR_HSHAKE);

  // Reset and shutdown priority; a link reset masks both shutdowns.
  wire hw_lrst   = ~pins.lreset_n;
  wire lpc_reset = hw_lrst | swrst_q;
  wire lpc_init  = reset | lpc_reset;
  wire hw_sd     = (hwsd_q | (lpcpd_fall & sden_q)) & ~lpc_reset;
  wire in_sd     = (hw_sd | swsd_q) & ~lpc_reset;
  wire seq_init  = lpc_reset | in_sd;
  wire active    = ~seq_init;
  wire sd_entry  = in_sd & ~insd_q;

  logic [17:0] allowed;
  always_comb
  begin
    allowed = 18'h00000;
    for (int c = 0; c < 4; c++)
      if (cfg_q[CFG_CHEN + c])
        allowed = allowed | CH_MASK[c];
  end
  wire [17:0] frame_req = (hirq_q & allowed) | (fifo_irq_req & MASK_FIFO);
  wire        pending   = |frame_req;

  // Control bit next values.
  always_comb
  begin
    sden_d  = wr_ctrl ? reg_wdata[CTRL_SDEN] : sden_q;
    swrst_d = wr_ctrl ? reg_wdata[CTRL_SWRST] : swrst_q;
    swsd_d  = wr_ctrl ? reg_wdata[CTRL_SWSD] : swsd_q;
    if (lpcpd_rise)
      sden_d = 1'b0;
    if (hw_sd)
      swsd_d = 1'b0;
    if (lpc_reset)
    begin
      sden_d = 1'b0;
      swsd_d = 1'b0;
    end
    if (hw_lrst)
      swrst_d = 1'b0;
    hwsd_d = hw_sd & ~lpcpd_rise;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      swsd_q  <= 1'b0;
      sden_q  <= 1'b0;
      swrst_q <= 1'b0;
      hwsd_q  <= 1'b0;
      insd_q  <= 1'b0;
    end
    else
    begin
      swsd_q  <= swsd_d;
      sden_q  <= sden_d;
      swrst_q <= swrst_d;
      hwsd_q  <= hwsd_d;
      insd_q  <= in_sd;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      cfg_q   <= CFG_RST;
      error_irq_enable_q <= 1'b0;
    end
    else
    begin
      if (wr_cfg)
        cfg_q <= reg_wdata[8:0];
      if (wr_ctrl)
        error_irq_enable_q <= reg_wdata[CTRL_ERROR_IRQ_ENABLE];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (lpc_init)
      sdflag_q <= 1'b0;
    else if (sd_entry)
      sdflag_q <= 1'b1;
    else if (wr_stat & reg_wdata[STAT_SDFLAG])
      sdflag_q <= 1'b0;
  end

  // Host enable bits lose their frames when a channel's output is read; for channels 2 to 4 only while that channel's clrmode bit is clear.
  always_comb
  begin
    hirq_d = wr_hirq ? reg_wdata[17:0] : hirq_q;
    for (int c = 0; c < 4; c++)
      if (hs_obf_clear[c] & ((c == 0) || !clrmode_q[(c > 0) ? c - 1 : 0]))
        hirq_d = hirq_d & ~CH_MASK[c];
  end

  always_ff @(posedge clk_sys)
  begin
    if (lpc_init)
    begin
      hirq_q    <= HIRQ_RST;
      clrmode_q <= 3'h0;
      quiet_q   <= QUIET_RST;
    end
    else
    begin
      hirq_q  <= hirq_d;
      quiet_q <= quiet_d;
      if (wr_ctrl)
        clrmode_q <= reg_wdata[CTRL_CLRMODE +: 3];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (lpc_init)
    begin
      obf_q <= 4'h0;
      ibf_q <= 4'h0;
      cd_q  <= 4'h0;
      a20_q <= A20_RST;
    end
    else
    begin
      // Host reads clear output flags; a software set in that cycle wins.
      obf_q <= (obf_q & ~hs_obf_clear) | (wr_hs ? reg_wdata[HS_OBF +: 4] : 4'h0);
      ibf_q <= (ibf_q & ~(wr_hs ? reg_wdata[HS_IBF +: 4] : 4'h0)) | hs_ibf_set;
      cd_q  <= (cd_q & ~hs_ibf_set) | (hs_cmd & hs_ibf_set);
      if (a20_write & cfg_q[CFG_A20_SEL])
        a20_q <= a20_value;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset | seq_init)
    begin
      busy_q   <= 1'b0;
      abort_q  <= 1'b0;
      clock_request_flag_q <= 1'b0;
    end
    else
    begin
      busy_q  <= xfer_start | (busy_q & ~xfer_done);
      abort_q <= xfer_abort | (abort_q & ~(wr_stat & reg_wdata[STAT_ABORT]));
      if (quiet_q & pending & (st_q == ST_IDLE) & cfg_q[CFG_CLOCK_REQUEST_FLAG]
          & (idle_cnt_q == LCLK_STOP_CYC))
        clock_request_flag_q <= 1'b1;
      else if (lclk_rise | lclk_fall)
        clock_request_flag_q <= 1'b0;
    end
  end

  // Time since the last link clock edge; the clock may stop in quiet mode.
  always_ff @(posedge clk_sys)
  begin
    if (reset | lclk_rise | lclk_fall)
      idle_cnt_q <= 8'h00;
    else if (idle_cnt_q != LCLK_STOP_CYC)
      idle_cnt_q <= idle_cnt_q + 8'h01;
  end

  // Line sampled mid-state, so host drive changes at the edge are never raced.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      smp_q <= 1'b1;
    else if (lclk_fall)
      smp_q <= pins.serirq;
  end

  always_comb
  begin
    st_d       = st_q;
    frame_d    = frame_q;
    phase_d    = phase_q;
    lows_d     = lows_q;
    drove_d    = drove_q;
    ser_o_d    = serirq_o;
    ser_oe_n_d = serirq_oe_n;
    quiet_d    = quiet_q;
    if (lclk_rise)
    begin
      case (st_q)
        ST_IDLE:
        begin
          lows_d = 3'd1;
          if (!smp_q)
            st_d = ST_START;
          else if (quiet_q & pending)
          begin
            st_d       = ST_SLAVE;
            ser_o_d    = 1'b0;
            ser_oe_n_d = 1'b0;
          end
        end
        ST_SLAVE:
        begin
          // Host takes over the remaining start states.
          ser_oe_n_d = 1'b1;
          st_d       = ST_START;
        end
        ST_START:
        begin
          if (!smp_q)
            lows_d = (lows_q == 3'd7) ? lows_q : lows_q + 3'd1;
          else
          begin
            // Host recovery seen; turnaround of the start frame follows.
            st_d    = ST_FRAME;
            frame_d = 5'd0;
            phase_d = PH_TURN;
          end
        end
        ST_FRAME:
        begin
          if (phase_q == PH_TURN)
          begin
            if (frame_q == LAST_FRAME)
            begin
              st_d   = ST_STOP;
              lows_d = 3'd0;
            end
            else
            begin
              frame_d = frame_q + 5'd1;
              phase_d = 2'd0;
              if (frame_req[frame_q + 5'd1])
              begin
                ser_o_d    = 1'b0;
                ser_oe_n_d = 1'b0;
                drove_d    = 1'b1;
              end
            end
          end
          else if (phase_q == 2'd0)
          begin
            phase_d = 2'd1;
            ser_o_d = 1'b1;
          end
          else
          begin
            phase_d = PH_TURN;
            ser_oe_n_d = 1'b1;
            drove_d    = 1'b0;
          end
        end
        ST_STOP:
        begin
          if (!smp_q)
            lows_d = (lows_q == 3'd7) ? lows_q : lows_q + 3'd1;
          else if (lows_q != 3'd0)
          begin
            quiet_d = (lows_q == STOP_QUIET);
            st_d    = ST_IDLE;
          end
        end
        default:
          st_d = ST_IDLE;
      endcase
    end
    if (seq_init)
    begin
      st_d       = ST_IDLE;
      ser_oe_n_d = 1'b1;
      drove_d    = 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      st_q        <= ST_IDLE;
      frame_q     <= 5'd0;
      phase_q     <= 2'd0;
      lows_q      <= 3'd0;
      drove_q     <= 1'b0;
      serirq_o    <= 1'b1;
      serirq_oe_n <= 1'b1;
    end
    else
    begin
      st_q        <= st_d;
      frame_q     <= frame_d;
      phase_q     <= phase_d;
      lows_q      <= lows_d;
      drove_q     <= drove_d;
      serirq_o    <= ser_o_d;
      serirq_oe_n <= ser_oe_n_d;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      lad_o         <= 4'h0;
      lad_oe_n      <= 1'b1;
      lframe_n_seen <= 1'b1;
      engine_reset  <= 1'b1;
      clkrun_o      <= 1'b0;
      clkrun_oe_n   <= 1'b1;
    end
    else
    begin
      lad_o         <= engine_lad_o;
      lad_oe_n      <= ~(engine_lad_drive & active);
      lframe_n_seen <= pins.lframe_n | seq_init;
      engine_reset  <= seq_init;
      clkrun_o      <= 1'b0;
      clkrun_oe_n   <= ~clock_request_flag_q | seq_init;
    end
  end

  wire [3:0] sb_sel  = {cfg_q[CFG_A20_SEL], cfg_q[CFG_SCI_SEL], cfg_q[CFG_SMI_SEL],
                        cfg_q[CFG_WAKE_SEL]};
  wire [3:0] sb_func = {a20_q, side_func_o};
  for (genvar i = 0; i < 4; i++)
  begin : g_side
    always_ff @(posedge clk_sys)
    begin
      if (reset)
      begin
        side_o[i]    <= 1'b0;
        side_oe_n[i] <= 1'b1;
      end
      else
      begin
        side_o[i]    <= sb_sel[i] ? sb_func[i] : side_port_o[i];
        side_oe_n[i] <= sb_sel[i] ? in_sd : side_port_oe_n[i];
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      error_interrupt <= 1'b0;
    else
      error_interrupt <= error_irq_enable_q & (sdflag_q | abort_q);
  end

  // Read data; unmapped offsets return zero.
  wire [31:0] rd_ctrl = {25'h0, clrmode_q, error_irq_enable_q, swrst_q, sden_q, swsd_q};
  wire [31:0] rd_stat = {22'h0, a20_q, quiet_q, (st_q != ST_IDLE), clock_request_flag_q, abort_q,
                         busy_q, lpc_reset, swsd_q & in_sd, hw_sd, sdflag_q};
  wire [31:0] rd_hs   = {20'h0, cd_q, ibf_q, obf_q};
  wire [31:0] rd_mux  = (reg_addr == ADDR_CTRL)   ? rd_ctrl :
                        (reg_addr == ADDR_CONFIG) ? {23'h0, cfg_q} :
                        (reg_addr == ADDR_STATUS) ? rd_stat :
                        (reg_addr == ADDR_HIRQ)   ? {14'h0, hirq_q} :
                        (reg_addr == ADDR_HSHAKE) ? rd_hs : 32'h0;

  // Read data stand for exactly the cycle after the strobe.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      reg_rdata <= 32'h0;
    else
      reg_rdata <= reg_rd ? rd_mux : 32'h0;
  end

endmodule : lpc_shutdown_reset_serirq

// ===== rtl/pin_sync_if.sv
`timescale 1ns/1ns
interface pin_sync_if;
  logic lreset_n;
  logic lpcpd_n;
  logic lclk;
  logic serirq;
  logic lframe_n;

  modport producer (output lreset_n, lpcpd_n, lclk, serirq, lframe_n);
  modport consumer (input lreset_n, lpcpd_n, lclk, serirq, lframe_n);
endinterface : pin_sync_if

// ===== testbench/lpc_host_model.sv
`timescale 1ns/1ns
// Host end of the serialized interrupt line, which has a pull-up.
module lpc_host_model
(
  // Device drive
  input  wire logic        serirq_o,
  input  wire logic        serirq_oe_n,
  // Link clock and resolved line
  output logic             lclk,
  output logic             serirq_i,
  // Frames seen driven low
  output logic      [17:0] seen_mask
);
  logic host_en;
  logic host_val;
  logic line_smp;

  // An undriven line floats up, so a stale level never shows.
  assign serirq_i = !serirq_oe_n ? serirq_o : (host_en ? host_val : 1'b1);

  // One state: the clock rises, drive changes, the line is sampled at the fall.
  task automatic state(input logic en, input logic val);
    lclk     = 1'b1;
    host_en  = en;
    host_val = val;
    #24;
    lclk     = 1'b0;
    line_smp = serirq_i;
    #24;
  endtask : state

  // One whole cycle; the clock then stands still low.
  task automatic cycle(input logic host_first, input int stops);
    int i;
    seen_mask = 18'h00000;
    // Start lows; in quiet mode the device owns the first one.
    state(host_first, 1'b0);
    repeat (3) state(1'b1, 1'b0);
    // Host restores high, then turns around.
    state(1'b1, 1'b1);
    state(1'b0, 1'b1);
    for (i = 0; i < 51; i++)
    begin
      state(1'b0, 1'b1);
      if (i % 3 == 0 && line_smp == 1'b0)
        seen_mask[i / 3 + 1] = 1'b1;
    end
    state(1'b0, 1'b1);
    repeat (stops) state(1'b1, 1'b0);
    // Recovery high, then a released turnaround closes the stop frame.
    state(1'b1, 1'b1);
    state(1'b0, 1'b1);
    host_en = 1'b0;
  endtask : cycle

  // Idle: clock still, line released.
  initial
  begin
    lclk      = 1'b0;
    host_en   = 1'b0;
    host_val  = 1'b1;
    line_smp  = 1'b1;
    seen_mask = 18'h00000;
  end
endmodule : lpc_host_model

// ===== testbench/lpc_sd_props.sv
`timescale 1ns/1ns
// Port checks on the shutdown, reset and serialized interrupt block.
module lpc_sd_props
(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        reset,
  // Watched ports
  input wire logic        lclk,
  input wire logic        serirq_i,
  input wire logic [31:0] reg_rdata,
  input wire logic        serirq_o,
  input wire logic        serirq_oe_n,
  input wire logic        clkrun_o,
  input wire logic        clkrun_oe_n,
  input wire logic [3:0]  engine_lad_o,
  input wire logic        engine_lad_drive,
  input wire logic [3:0]  lad_o,
  input wire logic        lad_oe_n,
  input wire logic        lframe_n_seen,
  input wire logic        engine_reset,
  input wire logic [3:0]  side_oe_n,
  input wire logic        error_interrupt
);
  // Every check runs on the system clock and rests during system reset.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_reset_outputs:
    assert property ($past(reset) |-> reg_rdata == 32'h0 && side_oe_n == 4'hf && serirq_oe_n
      && clkrun_oe_n && lad_oe_n && engine_reset && !error_interrupt)
    else $error("outputs not at reset values");
  a_engine_bus_off:
    assert property (engine_reset && $past(engine_reset) |-> lad_oe_n && serirq_oe_n)
    else $error("bus pins driven while held in reset");
  a_frame_masked:
    assert property (engine_reset && $past(engine_reset) |-> lframe_n_seen)
    else $error("frame pin passed while held in reset");
  a_clkrun_held:
    assert property (engine_reset && $past(engine_reset) |-> clkrun_oe_n)
    else $error("clock request while held in reset");
  a_low_state_ends:
    assert property (!serirq_oe_n && !serirq_o && $rose(lclk) |-> ##[1:20] (serirq_o || serirq_oe_n))
    else $error("low drive lasts beyond its state");
  a_recover_release:
    assert property ($rose(serirq_oe_n) && !$past(serirq_o) && !engine_reset |-> !serirq_i)
    else $error("line released low without recovery");
  a_clkrun_level:
    assert property (!clkrun_oe_n |-> !clkrun_o)
    else $error("clock request not driven low");
  a_lad_copy:
    assert property (!lad_oe_n |-> lad_o == $past(engine_lad_o) && $past(engine_lad_drive)
      && !engine_reset)
    else $error("address-data drive does not follow engine");
endmodule : lpc_sd_props

bind lpc_shutdown_reset_serirq lpc_sd_props lpc_sd_props_inst (.clk_sys(clk_sys), .reset(reset),
  .lclk(lclk), .serirq_i(serirq_i), .reg_rdata(reg_rdata), .serirq_o(serirq_o),
  .serirq_oe_n(serirq_oe_n), .clkrun_o(clkrun_o), .clkrun_oe_n(clkrun_oe_n),
  .engine_lad_o(engine_lad_o), .engine_lad_drive(engine_lad_drive), .lad_o(lad_o),
  .lad_oe_n(lad_oe_n), .lframe_n_seen(lframe_n_seen), .engine_reset(engine_reset),
  .side_oe_n(side_oe_n), .error_interrupt(error_interrupt));

// ===== testbench/tb_lpc_shutdown_reset_serirq.sv
`timescale 1ns/1ns
module tb_lpc_shutdown_reset_serirq import lpc_sd_pkg::*; ;
  typedef struct packed {logic [7:0] addr; logic [31:0] wdata; logic wr; logic [31:0] exp;} row_type;
  logic        clk_sys, reset, reg_wr, reg_rd, lpc_reset_n, power_down_n, lclk, serirq_i;
  logic        serirq_o, serirq_oe_n, clkrun_o, clkrun_oe_n, xfer_abort;
  logic        lad_oe_n, engine_reset, lframe_n_seen, error_interrupt;
  logic        xfer_start, xfer_done, a20_write, a20_value, lframe_n_i, engine_lad_drive;
  logic [3:0]  engine_lad_o, hs_ibf_set, hs_cmd, hs_obf_clear;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [3:0]  lad_o, side_o, side_oe_n;
  logic [17:0] fifo_irq_req, seen_mask;
  int          miscompares, check_count, i;
  row_type     rows [9] = '{'{ADDR_CTRL, 32'h0, 1'b0, 32'h0}, '{ADDR_CONFIG, 32'h0, 1'b0, 32'h0},
    '{ADDR_HIRQ, 32'h0, 1'b0, 32'h0}, '{ADDR_HSHAKE, 32'h0, 1'b0, 32'h0},
    '{8'h14, 32'hff, 1'b1, 32'h0}, '{ADDR_CONFIG, 32'h1ff, 1'b1, 32'h1ff},
    '{ADDR_HIRQ, 32'h1fffc, 1'b1, 32'h1fffc}, '{ADDR_HSHAKE, 32'hf, 1'b1, 32'hf},
    '{ADDR_CTRL, 32'h0a, 1'b1, 32'h0a}};

  lpc_shutdown_reset_serirq lpc_shutdown_reset_serirq_inst (.clk_sys(clk_sys), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .lpc_reset_n(lpc_reset_n), .power_down_n(power_down_n), .lclk(lclk),
    .serirq_i(serirq_i), .lframe_n_i(lframe_n_i), .serirq_o(serirq_o), .serirq_oe_n(serirq_oe_n),
    .clkrun_o(clkrun_o), .clkrun_oe_n(clkrun_oe_n), .engine_lad_o(engine_lad_o),
    .engine_lad_drive(engine_lad_drive), .lad_o(lad_o), .lad_oe_n(lad_oe_n),
    .lframe_n_seen(lframe_n_seen), .engine_reset(engine_reset), .xfer_start(xfer_start),
    .xfer_done(xfer_done), .xfer_abort(xfer_abort), .hs_ibf_set(hs_ibf_set), .hs_cmd(hs_cmd),
    .hs_obf_clear(hs_obf_clear), .a20_write(a20_write), .a20_value(a20_value),
    .fifo_irq_req(fifo_irq_req), .side_func_o(3'h5), .side_port_o(4'ha), .side_port_oe_n(4'h0),
    .side_o(side_o), .side_oe_n(side_oe_n), .error_interrupt(error_interrupt));

  lpc_host_model lpc_host_model_inst (.serirq_o(serirq_o), .serirq_oe_n(serirq_oe_n),
    .lclk(lclk), .serirq_i(serirq_i), .seen_mask(seen_mask));

  // System clock.
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // Compare one value; an unknown never matches.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
      begin
      miscompares++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
      end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 chk(reg_rdata & m, e);
  endtask : rd

  // Bounded wait; the synchroniser adds a few cycles.
  task automatic wait_engine(input logic lvl);
    i = 0;
    while (engine_reset !== lvl && i < 40)
    begin
      @(posedge clk_sys);
      i++;
    end
  endtask : wait_engine

  task automatic stop_test();
    if (miscompares == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  // Main sequence.
  initial
  begin
    {reset, lpc_reset_n, power_down_n} = 3'b111;
    {reg_addr, reg_wdata, reg_wr, reg_rd, xfer_abort, fifo_irq_req} = '0;
    {xfer_start, xfer_done, a20_write, a20_value, hs_ibf_set, hs_cmd, hs_obf_clear} = '0;
    {lframe_n_i, engine_lad_drive, engine_lad_o} = 6'h35;
    {miscompares, check_count} = '0;
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (4) @(posedge clk_sys);
    foreach (rows[k])
    begin
      if (rows[k].wr)
        wr(rows[k].addr, rows[k].wdata);
      rd(rows[k].addr, 32'hffffffff, rows[k].exp);
    end
    rd(ADDR_STATUS, 32'h200, 32'h200);
    // Engine, handshake and gate events all land in one cycle.
    @(posedge clk_sys) {xfer_abort, xfer_start, a20_write} <= 3'b111;
    {hs_ibf_set, hs_cmd, hs_obf_clear} <= 12'h311;
    @(posedge clk_sys) {xfer_abort, xfer_start, a20_write} <= 3'b000;
    {hs_ibf_set, hs_cmd, hs_obf_clear} <= 12'h000;
    rd(ADDR_STATUS, 32'h230, 32'h030);
    @(posedge clk_sys) {power_down_n, lframe_n_i} <= 2'b00;
    wait_engine(1'b1);
    chk({31'h0, i <= 6}, 32'h1);
    chk({31'h0, lframe_n_seen}, 32'h1);
    rd(ADDR_STATUS, 32'h231, 32'h001);
    chk({31'h0, error_interrupt}, 32'h1);
    chk({28'h0, side_oe_n}, 32'hf);
    @(posedge clk_sys) power_down_n <= 1'b1;
    wait_engine(1'b0);
    chk({31'h0, lframe_n_seen}, 32'h0);
    rd(ADDR_CTRL, 32'hff, 32'h08);
    rd(ADDR_HSHAKE, 32'hfff, 32'h13e);
    rd(ADDR_HIRQ, 32'h3ffff, 32'h1dff8);
    wr(ADDR_STATUS, 32'h1);
    rd(ADDR_STATUS, 32'h1, 32'h0);
    @(posedge clk_sys) chk({31'h0, error_interrupt}, 32'h0);
    wr(ADDR_CTRL, 32'h3);
    @(posedge clk_sys) power_down_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rd(ADDR_CTRL, 32'h3, 32'h2);
    @(posedge clk_sys) power_down_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    rd(ADDR_CTRL, 32'h3, 32'h0);
    wr(ADDR_CTRL, 32'h7);
    rd(ADDR_CTRL, 32'h7, 32'h4);
    wr(ADDR_CTRL, 32'h1);
    @(posedge clk_sys) lpc_reset_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    chk({28'h0, side_oe_n}, 32'h0);
    rd(ADDR_CTRL, 32'hff, 32'h0);
    rd(ADDR_HSHAKE, 32'hfff, 32'h0);
    rd(ADDR_HIRQ, 32'h3ffff, 32'h0);
    rd(ADDR_CONFIG, 32'h1ff, 32'h1ff);
    rd(ADDR_STATUS, 32'h200, 32'h200);
    @(posedge clk_sys) lpc_reset_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
    fifo_irq_req <= 18'h30021;
    #1 lpc_host_model_inst.cycle(1'b1, 3);
    chk({14'h0, seen_mask}, 32'h10020);
    #1 lpc_host_model_inst.cycle(1'b1, 2);
    rd(ADDR_STATUS, 32'h100, 32'h100);
    i = 0;
    while (clkrun_oe_n !== 1'b0 && i < 200)
    begin
      @(posedge clk_sys);
      i++;
    end
    chk({31'h0, clkrun_oe_n}, 32'h0);
    #1 lpc_host_model_inst.cycle(1'b0, 3);
    chk({14'h0, seen_mask}, 32'h10020);
    // A system reset in mid-run clears even the operation controls.
    @(posedge clk_sys) reset <= 1'b1;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    rd(ADDR_CONFIG, 32'h1ff, 32'h0);
    stop_test();
  end

  // Watchdog well beyond the expected run.
  initial
  begin
    #300000;
    miscompares++;
    stop_test();
  end
endmodule : tb_lpc_shutdown_reset_serirq
